/* hdl/fpdk_panel.sv */
// Front panel logic: display multiplexer with memory and keyboard scanner.
// Assumes port lines arrive from another board and are synchronised here;
// column inputs are pulled high and go low when a key is pressed.
`timescale 1ns/10ps
// Operation
// - Update select low stops display multiplexing
// - Update mode steps counter on port clock
// - Clear/load with clock clears digit counter
// - Read select low drives all rows low
// - Idle columns high give detect zero
// - Low column raises detect, starts debounce
// - Debounced held key raises interrupt
// - Read select high enables key buffer
// - Clear/load with clock loads rows 0111
// - Further clocks rotate the low row bit
// - Processor returns read select low afterwards
// - Scan clock steps counter, decoded digit drive
// - Twelve digits plus three annunciator groups
module fpdk_panel
    import fpdk_pkg::*;
#(
    parameter int DEBOUNCE_CYC = FPDK_DEBOUNCE_CYC,
    parameter int SCAN_DIV = FPDK_SCAN_DIV
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Processor side
    fpdk_if.panel port,
    // Keyboard matrix
    input wire logic [FPDK_COLS-1:0] i_col_sense,
    output logic [FPDK_ROWS-1:0] o_row_drive,
    // Display drivers
    output logic [FPDK_SEL_W-1:0] o_digit_sel,
    output logic [FPDK_SEG_W-1:0] o_seg
);
    // ==================================================================
    // Input synchronisers
    logic [3:0] ctl_meta_r; // First stage, read only by second stage
    logic [3:0] ctl_sync_r; // Synchronised control lines
    logic [FPDK_SEG_W-1:0] dat_meta_r; // First stage of segment data
    logic [FPDK_SEG_W-1:0] dat_sync_r; // Synchronised segment data
    logic [FPDK_COLS-1:0] col_meta_r; // First stage of columns
    logic [FPDK_COLS-1:0] col_sync_r; // Synchronised columns
    logic step_d_r; // Previous step clock level
    logic upd_mode; // Memory update mode
    logic krd_mode; // Keyboard read mode
    logic clr_ld; // Clear/load level
    logic step_rise; // Port clock rising edge

    // Two flip-flops on every line coming from the other board
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctl_meta_r <= 4'h1;
            ctl_sync_r <= 4'h1;
            dat_meta_r <= '0;
            dat_sync_r <= '0;
            col_meta_r <= FPDK_COL_IDLE;
            col_sync_r <= FPDK_COL_IDLE;
        end else begin
            ctl_meta_r <= {port.key_read_select, port.clear_load_line, port.port_step_clock,
                           port.scan_update_select};
            ctl_sync_r <= ctl_meta_r;
            dat_meta_r <= port.seg_data;
            dat_sync_r <= dat_meta_r;
            col_meta_r <= i_col_sense;
            col_sync_r <= col_meta_r;
        end
    end

    // The processor end stretches each step pulse over several clocks; a
    // pulse shorter than two clocks could slip past the synchroniser unseen
    // Edge detector looks only at the second stage
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            step_d_r <= 1'b0;
        end else begin
            step_d_r <= ctl_sync_r[1];
        end
    end

    assign upd_mode = !ctl_sync_r[0];
    assign step_rise = ctl_sync_r[1] && !step_d_r;
    assign clr_ld = ctl_sync_r[2];
    assign krd_mode = ctl_sync_r[3];

    // ==================================================================
    // Display scan clock and digit counter
    logic [$clog2(SCAN_DIV)-1:0] div_r; // Scan clock divider
    logic scan_tick; // One-cycle display scan clock
    logic [FPDK_CNT_W-1:0] digit_counter_r; // Current digit position
    logic [FPDK_CNT_W-1:0] digit_counter_nxt; // Next position, wraps at last
    logic [FPDK_SEG_W-1:0] mem_r [FPDK_NUM_POS]; // Display memory, one pattern per position

    // Free-running divider
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end
    assign scan_tick = (div_r == '1);

    // Fifteen positions, wrap after last annunciator group
    assign digit_counter_nxt = (digit_counter_r == FPDK_CNT_LAST) ? FPDK_CNT_FIRST : digit_counter_r + 1'b1;

    // Counter stepping per mode
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            digit_counter_r <= FPDK_CNT_FIRST;
        end else if (upd_mode) begin
            if (step_rise) begin
                if (clr_ld) begin
                    digit_counter_r <= FPDK_CNT_FIRST;
                end else begin
                    digit_counter_r <= digit_counter_nxt;
                end
            end
        end else if (scan_tick) begin
            digit_counter_r <= digit_counter_nxt;
        end
    end

    // No reset on the memory: self-scan shows stale patterns until all
    // fifteen positions have been written once
    // Memory write on update clocks that are not clears
    always_ff @(posedge i_clk_sys) begin
        if (upd_mode && step_rise && !clr_ld) begin
            mem_r[digit_counter_r] <= dat_sync_r;
        end
    end

    // Digit decode and segment drive, blanked in update mode
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_digit_sel <= '0;
            o_seg <= '0;
        end else if (upd_mode) begin
            o_digit_sel <= '0;
            o_seg <= '0;
        end else begin
            o_digit_sel <= FPDK_SEL_W'(1) << digit_counter_r;
            o_seg <= mem_r[digit_counter_r];
        end
    end

    // ==================================================================
    // Keyboard scanning
    logic [FPDK_ROWS-1:0] row_shift_register_r; // Row drive pattern
    logic key_detect_gate; // NAND of the columns
    logic key_stable; // Debounced key detect

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            row_shift_register_r <= FPDK_ROW_IDLE;
        end else if (!krd_mode) begin
            row_shift_register_r <= FPDK_ROW_IDLE;
        end else if (step_rise) begin
            if (clr_ld) begin
                row_shift_register_r <= FPDK_ROW_LOAD;
            end else begin
                row_shift_register_r <= {row_shift_register_r[FPDK_ROWS-2:0], row_shift_register_r[FPDK_ROWS-1]};
            end
        end
    end
    assign o_row_drive = row_shift_register_r;

    // Key detect as NAND of columns
    assign key_detect_gate = ~&col_sync_r;

    fpdk_debounce #(
        .CYCLES(DEBOUNCE_CYC)
    ) u_debounce (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_level(key_detect_gate),
        .o_stable(key_stable)
    );

    assign port.key_irq = key_stable;

    // Key data buffer onto processor path
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            port.row_lines <= '0;
            port.col_lines <= '0;
            port.key_buf_valid <= 1'b0;
        end else if (krd_mode) begin
            port.row_lines <= row_shift_register_r;
            port.col_lines <= col_sync_r;
            port.key_buf_valid <= 1'b1;
        end else begin
            port.row_lines <= '0;
            port.col_lines <= '0;
            port.key_buf_valid <= 1'b0;
        end
    end
endmodule : fpdk_panel

/* hdl/fpdk_pkg.sv */
// Constants shared by both ends of the front panel display and keyboard link.
// Assumes a single 250 MHz system clock on both ends.
package fpdk_pkg;
    // ==================================================================
    // Display geometry
    localparam int FPDK_NUM_DIGITS = 12;
    localparam int FPDK_NUM_ANNUN = 3;
    localparam int FPDK_NUM_POS = FPDK_NUM_DIGITS + FPDK_NUM_ANNUN;
    localparam int FPDK_SEG_W = 8;
    localparam int FPDK_CNT_W = 4;
    localparam int FPDK_SEL_W = 16;
    localparam logic [FPDK_CNT_W-1:0] FPDK_CNT_FIRST = 4'h0;
    localparam logic [FPDK_CNT_W-1:0] FPDK_CNT_LAST = 4'hE;
    // ==================================================================
    // Keyboard geometry
    localparam int FPDK_ROWS = 4;
    localparam int FPDK_COLS = 8;
    localparam logic [FPDK_ROWS-1:0] FPDK_ROW_LOAD = 4'h7;
    localparam logic [FPDK_ROWS-1:0] FPDK_ROW_IDLE = 4'h0;
    localparam logic [FPDK_COLS-1:0] FPDK_COL_IDLE = 8'hFF;
    // ==================================================================
    // Timing
    localparam int FPDK_CLK_MHZ = 250;
    localparam int FPDK_DEBOUNCE_US = 20;
    localparam int FPDK_DEBOUNCE_CYC = FPDK_DEBOUNCE_US * FPDK_CLK_MHZ;
    localparam int FPDK_SCAN_DIV = 64;
    localparam int FPDK_STEP_HALF = 4;
    // ==================================================================
    // Controller register offsets
    localparam logic [3:0] FPDK_REG_CTRL = 4'h0;
    localparam logic [3:0] FPDK_REG_CMD = 4'h1;
    localparam logic [3:0] FPDK_REG_WDATA = 4'h2;
    localparam logic [3:0] FPDK_REG_STAT = 4'h3;
    localparam logic [3:0] FPDK_REG_KEYS = 4'h4;
    // Control register bits
    localparam int FPDK_CTRL_UPD = 0;
    localparam int FPDK_CTRL_KRD = 1;
    localparam int FPDK_CTRL_CLR = 2;
    // Command register bits
    localparam int FPDK_CMD_STEP = 0;
endpackage : fpdk_pkg

/* hdl/fpdk_if.sv */
// Interface carrying the parallel port lines and keyboard sense lines.
// Assumes both ends share i_clk_sys; the testbench joins the ends.
`timescale 1ns/10ps
interface fpdk_if;
    import fpdk_pkg::*;
    logic scan_update_select; // 1 self-scan, 0 memory update
    logic port_step_clock; // Processor step clock
    logic clear_load_line; // Clear/load control
    logic key_read_select; // 1 read keys, 0 scan
    logic [FPDK_SEG_W-1:0] seg_data; // Segment pattern written to memory
    logic key_irq; // Key pressed interrupt, active high
    logic [FPDK_ROWS-1:0] row_lines; // Buffered row lines
    logic [FPDK_COLS-1:0] col_lines; // Buffered column lines
    logic key_buf_valid; // Key data buffer enabled
    modport panel (input scan_update_select, port_step_clock, clear_load_line, key_read_select, seg_data,
                   output key_irq, row_lines, col_lines, key_buf_valid);
    modport proc (output scan_update_select, port_step_clock, clear_load_line, key_read_select, seg_data,
                  input key_irq, row_lines, col_lines, key_buf_valid);
endinterface : fpdk_if

/* hdl/fpdk_debounce.sv */
// Debounce filter: output rises after input held high for a full count.
// Assumes the input is already synchronised to i_clk_sys.
`timescale 1ns/10ps
module fpdk_debounce #(
    parameter int CYCLES = 5000
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Filter
    input wire logic i_level,
    output logic o_stable
);
    // ==================================================================
    // Hold counter
    logic [$clog2(CYCLES+1)-1:0] cnt_r; // Cycles the input has been held

    // Count while held, restart on any release
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r <= '0;
        end else if (!i_level) begin
            cnt_r <= '0;
        end else if (cnt_r != CYCLES[$bits(cnt_r)-1:0]) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Output flag register
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_stable <= 1'b0;
        end else begin
            o_stable <= i_level && (cnt_r == CYCLES[$bits(cnt_r)-1:0]);
        end
    end
endmodule : fpdk_debounce

/* hdl/fpdk_proc.sv */
// Processor end: registers drive the port lines; software sequences them.
// Assumes same clock as the panel; simple strobe register port.
`timescale 1ns/10ps
module fpdk_proc
    import fpdk_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Panel side
    fpdk_if.proc port
);
    // ==================================================================
    // Control state
    logic [2:0] ctrl_r; // Update, read select, clear/load
    logic [FPDK_SEG_W-1:0] wdata_r; // Segment data
    logic [3:0] step_cnt_r; // Step pulse timer
    logic [FPDK_COLS-1:0] col_meta_r; // Column sync first stage
    logic [FPDK_COLS-1:0] col_sync_r; // Column sync second stage
    logic [FPDK_ROWS-1:0] row_meta_r; // Row sync first stage
    logic [FPDK_ROWS-1:0] row_sync_r; // Row sync second stage
    logic [1:0] irq_meta_r; // Irq and valid sync first stage
    logic [1:0] irq_sync_r; // Irq and valid sync second stage

    // Register writes; reset to self-scan, scan select high
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_r <= 3'h0;
            wdata_r <= '0;
        end else if (i_wr && i_addr == FPDK_REG_CTRL) begin
            ctrl_r <= i_wdata[2:0];
        end else if (i_wr && i_addr == FPDK_REG_WDATA) begin
            wdata_r <= i_wdata[FPDK_SEG_W-1:0];
        end
    end

    // Step pulse: high then low, each FPDK_STEP_HALF cycles
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            step_cnt_r <= 4'h0;
        end else if (step_cnt_r != 4'h0) begin
            step_cnt_r <= step_cnt_r - 4'h1;
        end else if (i_wr && i_addr == FPDK_REG_CMD && i_wdata[FPDK_CMD_STEP]) begin
            step_cnt_r <= 4'(2 * FPDK_STEP_HALF);
        end
    end

    // Panel outputs
    assign port.scan_update_select = !ctrl_r[FPDK_CTRL_UPD];
    assign port.key_read_select = ctrl_r[FPDK_CTRL_KRD];
    assign port.clear_load_line = ctrl_r[FPDK_CTRL_CLR];
    assign port.seg_data = wdata_r;
    assign port.port_step_clock = (step_cnt_r > 4'(FPDK_STEP_HALF));

    // Synchronise panel returns
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            col_meta_r <= '0;
            col_sync_r <= '0;
            row_meta_r <= '0;
            row_sync_r <= '0;
            irq_meta_r <= '0;
            irq_sync_r <= '0;
        end else begin
            col_meta_r <= port.col_lines;
            col_sync_r <= col_meta_r;
            row_meta_r <= port.row_lines;
            row_sync_r <= row_meta_r;
            irq_meta_r <= {port.key_buf_valid, port.key_irq};
            irq_sync_r <= irq_meta_r;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                FPDK_REG_CTRL: o_rdata <= {29'h0, ctrl_r};
                FPDK_REG_WDATA: o_rdata <= {24'h0, wdata_r};
                FPDK_REG_STAT: o_rdata <= {29'h0, step_cnt_r != 4'h0, irq_sync_r};
                FPDK_REG_KEYS: o_rdata <= {20'h0, row_sync_r, col_sync_r};
                default: o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end
endmodule : fpdk_proc

/* bench/fpdk_chk.sv */
// Checker for the front panel link: port lines and panel pins.
// Assumes one clock; placed beside the link by the testbench.
`timescale 1ns/10ps
module fpdk_chk
    import fpdk_pkg::*;
#(
    parameter int DEBOUNCE_CYC = 8
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Link lines
    input wire logic scan_update_select,
    input wire logic clear_load_line,
    input wire logic key_read_select,
    input wire logic key_irq,
    input wire logic [FPDK_ROWS-1:0] row_lines,
    input wire logic [FPDK_COLS-1:0] col_lines,
    input wire logic key_buf_valid,
    // Panel pins
    input wire logic [FPDK_COLS-1:0] i_col_sense,
    input wire logic [FPDK_ROWS-1:0] o_row_drive,
    input wire logic [FPDK_SEL_W-1:0] o_digit_sel
);
    // ==========================================================
    // Held key counter
    logic [15:0] hold_r; // Cycles with some column low
    // Counts while any column is low, saturates
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hold_r <= 16'h0;
        end else if (i_col_sense == FPDK_COL_IDLE) begin
            hold_r <= 16'h0;
        end else if (hold_r != 16'hFFFF) begin
            hold_r <= hold_r + 16'h1;
        end
    end
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    // ==========================================================
    // Assertions
    a_update_blanks_digits: assert property (!scan_update_select [*5] |-> o_digit_sel == '0)
        else $error("Digits driven in update mode");
    a_scan_rows_idle: assert property (!key_read_select [*5] |-> o_row_drive == '0)
        else $error("Rows not idle while scanning");
    a_buffer_off: assert property (!key_read_select [*5] |-> !key_buf_valid && row_lines == '0 && col_lines == '0)
        else $error("Key buffer on while scanning");
    a_buffer_on: assert property (key_read_select [*5] |-> key_buf_valid)
        else $error("Key buffer off while reading");
    a_idle_no_irq: assert property ((i_col_sense == FPDK_COL_IDLE) [*6] |-> !key_irq)
        else $error("Interrupt with no key pressed");
    a_irq_after_hold: assert property ($rose(key_irq) |-> $past(hold_r, 4) >= DEBOUNCE_CYC / 2)
        else $error("Interrupt before debounce");
    a_irq_bounded: assert property (hold_r == DEBOUNCE_CYC + 8 |-> key_irq)
        else $error("No interrupt for held key");
    a_row_single_low: assert property (key_read_select && o_row_drive != '0
        |-> o_row_drive inside {4'h7, 4'hE, 4'hD, 4'hB})
        else $error("Row pattern not one low");
    a_row_rotates: assert property ($past(o_row_drive) != '0 && o_row_drive != '0 && !clear_load_line
        && o_row_drive != $past(o_row_drive)
        |-> o_row_drive == {$past(o_row_drive[2:0]), $past(o_row_drive[3])})
        else $error("Row shift wrong");
    a_digit_onehot: assert property (o_digit_sel != '0 |-> $onehot(o_digit_sel) && !o_digit_sel[15])
        else $error("Digit select not one of fifteen");
    // Main scenarios reached
    c_irq: cover property ($rose(key_irq));
    c_buf: cover property ($rose(key_buf_valid));
    c_upd: cover property ($fell(scan_update_select));
    c_row: cover property (o_row_drive == 4'hB);
endmodule : fpdk_chk

/* bench/tb_top.sv */
// Testbench: drives the processor end over its register port and
// models one key (row 1, column 3) on the panel end.
// Assumes both ends share the 250 MHz clock.
`timescale 1ns/10ps
module tb_top
    import fpdk_pkg::*;
;
    localparam int DEB = 8; // Short debounce
    localparam logic [11:0] KEXP [4] = '{12'h7FF, 12'hEFF, 12'hDF7, 12'hBFF}; // Rows, cols per step
    logic i_clk_sys, i_arst_n, i_wr, i_rd, key_on;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [7:0] col_r, o_seg;
    logic [3:0] o_row_drive;
    logic [15:0] o_digit_sel, seen;
    int n_fail, tests_run;
    fpdk_if port_if();
    fpdk_proc i_fpdk_proc(.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .port(port_if));
    fpdk_panel #(.DEBOUNCE_CYC(DEB), .SCAN_DIV(4)) i_fpdk_panel(.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .port(port_if), .i_col_sense(col_r), .o_row_drive(o_row_drive), .o_digit_sel(o_digit_sel), .o_seg(o_seg));
    fpdk_chk #(.DEBOUNCE_CYC(DEB)) i_fpdk_chk(.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .scan_update_select(port_if.scan_update_select), .clear_load_line(port_if.clear_load_line),
        .key_read_select(port_if.key_read_select), .key_irq(port_if.key_irq), .row_lines(port_if.row_lines),
        .col_lines(port_if.col_lines), .key_buf_valid(port_if.key_buf_valid), .i_col_sense(col_r),
        .o_row_drive(o_row_drive), .o_digit_sel(o_digit_sel));
    // Clock
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    // Key matrix: column 3 low while row 1 is driven low
    always @(posedge i_clk_sys) begin
        col_r <= (key_on && !o_row_drive[1]) ? 8'hF7 : 8'hFF;
    end
    // ==========================================================
    // Tasks
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask : chk_pin
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk_reg(o_rdata, exp);
    endtask : rd
    // One step pulse, then wait out pulse and sync delay
    task automatic step();
        wr(FPDK_REG_CMD, 32'h1);
        repeat (20) @(posedge i_clk_sys);
    endtask : step
    function automatic logic [7:0] pat(input int k);
        return 8'(k * 17) ^ 8'h5A;
    endfunction : pat
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    // Hang guard
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        int k, n;
        {i_arst_n, i_wr, i_rd, key_on, i_addr, i_wdata, n_fail, tests_run} = '0;
        repeat (2) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        rd(FPDK_REG_STAT, 32'h0);
        chk_pin(16'(port_if.scan_update_select), 16'h1);
        rd(4'hF, 32'h0);
        repeat (30) @(posedge i_clk_sys);
        wr(FPDK_REG_CTRL, 32'h5);
        rd(FPDK_REG_CTRL, 32'h5);
        step();
        wr(FPDK_REG_CTRL, 32'h1);
        chk_pin(o_digit_sel, 16'h0);
        chk_pin(16'(o_seg), 16'h0);
        for (k = 0; k < FPDK_NUM_POS; k++) begin
            wr(FPDK_REG_WDATA, 32'(pat(k)));
            rd(FPDK_REG_WDATA, 32'(pat(k)));
            step();
        end
        wr(FPDK_REG_CTRL, 32'h0);
        seen = '0;
        for (n = 0; n < 200; n++) begin
            @(posedge i_clk_sys);
            #1;
            for (k = 0; k < FPDK_NUM_POS; k++) begin
                if (o_digit_sel === 16'(1 << k)) begin
                    seen[k] = 1'b1;
                    chk_pin(16'(o_seg), 16'(pat(k)));
                end
            end
        end
        chk_pin(seen, 16'h7FFF);
        // Short press is filtered, long press interrupts
        key_on <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        key_on <= 1'b0;
        repeat (20) @(posedge i_clk_sys);
        rd(FPDK_REG_STAT, 32'h0);
        key_on <= 1'b1;
        repeat (DEB + 20) @(posedge i_clk_sys);
        rd(FPDK_REG_STAT, 32'h1);
        // Keyboard read with the key held
        wr(FPDK_REG_CTRL, 32'h2);
        repeat (10) @(posedge i_clk_sys);
        rd(FPDK_REG_STAT, 32'h3);
        wr(FPDK_REG_CTRL, 32'h6);
        step();
        wr(FPDK_REG_CTRL, 32'h2);
        for (k = 0; k < 4; k++) begin
            if (k == 1) begin
                // A step command in the low half of a running pulse is ignored
                wr(FPDK_REG_CMD, 32'h1);
                rd(FPDK_REG_STAT, 32'h6);
                rd(FPDK_REG_STAT, 32'h6);
                wr(FPDK_REG_CMD, 32'h1);
                repeat (20) @(posedge i_clk_sys);
            end else if (k > 1) begin
                step();
            end
            chk_pin(16'(o_row_drive), 16'(KEXP[k][11:8]));
            rd(FPDK_REG_KEYS, 32'(KEXP[k]));
        end
        key_on <= 1'b0;
        wr(FPDK_REG_CTRL, 32'h0);
        repeat (20) @(posedge i_clk_sys);
        chk_pin(16'(o_row_drive), 16'h0);
        rd(FPDK_REG_STAT, 32'h0);
        rd(FPDK_REG_KEYS, 32'h0);
        end_of_test();
    end
endmodule : tb_top
